// *** design/ppps_params.svh ***
// Constants for the pixel port palette select block.
`ifndef PPPS_PARAMS_SVH
`define PPPS_PARAMS_SVH

`define PPPS_ENTRIES      256
`define PPPS_OVERLAYS     3
`define PPPS_SEL_MAIN     2'h0
`define PPPS_BLANK_LEVEL  8'h00
`define PPPS_BLACK_LEVEL  8'h00

`endif

// *** design/ppps_pkg.sv ***
// Types for the pixel port palette select block.
`default_nettype none

package ppps_pkg;

  typedef struct packed
  {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } ppps_colour_t;

  typedef struct packed
  {
    logic [7:0] pixel_index;
    logic [1:0] overlay_select;
    logic       blank_n;
    logic       sync_n;
  } ppps_pixel_in_t;

  typedef enum logic [1:0]
  {
    PPPS_SRC_MAIN,
    PPPS_SRC_OVERLAY,
    PPPS_SRC_BLANK,
    PPPS_SRC_BLACK
  } ppps_source_t;

endpackage : ppps_pkg

`default_nettype wire

// *** design/ppps_pixel_port.sv ***
// Pixel port front end choosing lookup, overlay, blanking or black colour.
`include "ppps_params.svh"
`default_nettype none

module ppps_pixel_port #(
  parameter int ENTRIES = `PPPS_ENTRIES
) (
  // Clock and reset.
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  // Pixel and control inputs.
  input  wire ppps_pkg::ppps_pixel_in_t pixel_i,
  input  wire logic                  chip_select_n_i,
  // Palette contents, loaded elsewhere.
  input  wire logic [24*ENTRIES-1:0] lookup_table_i,
  input  wire logic [24*3-1:0]       overlay_colours_i,
  // Colour levels and sync current enable.
  output ppps_pkg::ppps_colour_t     colour_current_outputs_o,
  output logic                       timing_current_out_o
);

  // ************************************************
  // Local sizes.
  // ************************************************

  // Width of one packed palette entry, three eight-bit levels.
  localparam int ENTRY_BITS = 24;
  localparam int LEVEL_BITS = 8;
  localparam int CHANNELS   = 3;

  // ************************************************
  // Decoding helpers.
  // ************************************************

  // Chip select beats blanking, which beats the overlay choice.
  function automatic ppps_pkg::ppps_source_t pick_source
  (
    input logic       cs_n,
    input logic       blank_n,
    input logic [1:0] overlay_sel
  );
    ppps_pkg::ppps_source_t source;

    if (cs_n == 1'b0)
    begin
      source = ppps_pkg::PPPS_SRC_BLACK;
    end
    else if (blank_n == 1'b0)
    begin
      source = ppps_pkg::PPPS_SRC_BLANK;
    end
    else if (overlay_sel != `PPPS_SEL_MAIN)
    begin
      source = ppps_pkg::PPPS_SRC_OVERLAY;
    end
    else
    begin
      source = ppps_pkg::PPPS_SRC_MAIN;
    end
    return source;
  endfunction : pick_source

  // Selector values one to three map onto overlay slots zero to two.
  function automatic logic [1:0] overlay_slot
  (
    input logic [1:0] overlay_sel
  );
    return overlay_sel - 2'h1;
  endfunction : overlay_slot

  // Repeats one level across all three channels.
  function automatic logic [23:0] fill_level
  (
    input logic [7:0] level
  );
    return {3{level}};
  endfunction : fill_level

  // ************************************************
  // Input capture.
  // ************************************************

  ppps_pkg::ppps_pixel_in_t captured;
  logic                     captured_cs_n;

  // Pixel data and both composite controls are latched together.
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      captured <= '0;
    end
    else
    begin
      captured <= pixel_i;
    end
  end

  // Chip select is latched on the same edge as the pixel data.
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      captured_cs_n <= 1'b1;
    end
    else
    begin
      captured_cs_n <= chip_select_n_i;
    end
  end

  // ************************************************
  // Colour source selection.
  // ************************************************

  ppps_pkg::ppps_source_t next_source;

  always_comb
  begin
    next_source = pick_source(
      captured_cs_n,
      captured.blank_n,
      captured.overlay_select
    );
  end

  // ************************************************
  // Colour fetch.
  // ************************************************

  logic [23:0] main_colour;
  logic [23:0] overlay_colour;
  logic [23:0] next_colour;

  // An index beyond a shortened table reads as black.
  always_comb
  begin
    main_colour = 24'h000000;
    if (32'(captured.pixel_index) < ENTRIES)
    begin
      main_colour = lookup_table_i[ENTRY_BITS*captured.pixel_index +: ENTRY_BITS];
    end
  end

  // Selector zero has no overlay slot, so the read is skipped then.
  always_comb
  begin
    overlay_colour = 24'h000000;
    if (captured.overlay_select != `PPPS_SEL_MAIN)
    begin
      overlay_colour = overlay_colours_i[ENTRY_BITS*overlay_slot(captured.overlay_select) +: ENTRY_BITS];
    end
  end

  always_comb
  begin
    next_colour = 24'h000000;
    unique case (next_source)
      ppps_pkg::PPPS_SRC_MAIN:
      begin
        next_colour = main_colour;
      end
      ppps_pkg::PPPS_SRC_OVERLAY:
      begin
        next_colour = overlay_colour;
      end
      ppps_pkg::PPPS_SRC_BLANK:
      begin
        next_colour = fill_level(`PPPS_BLANK_LEVEL);
      end
      ppps_pkg::PPPS_SRC_BLACK:
      begin
        next_colour = fill_level(`PPPS_BLACK_LEVEL);
      end
    endcase
  end

  // ************************************************
  // Output stage.
  // ************************************************

  wire logic [23:0] colour_level;

  // One register bank per colour channel.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_channel
      logic [LEVEL_BITS-1:0] level;

      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          level <= '0;
        end
        else
        begin
          level <= next_colour[LEVEL_BITS*ch +: LEVEL_BITS];
        end
      end

      assign colour_level[LEVEL_BITS*ch +: LEVEL_BITS] = level;
    end
  endgenerate

  assign colour_current_outputs_o = colour_level;

  // ************************************************
  // Sync current.
  // ************************************************

  // Sync only gates its own current and overrides nothing else.
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      timing_current_out_o <= 1'b0;
    end
    else
    begin
      timing_current_out_o <= captured.sync_n;
    end
  end

endmodule : ppps_pixel_port

`default_nettype wire

// *** bench/ppps_props.sv ***
// Checker for the pixel port outputs.
`default_nettype none
module ppps_props #(parameter int ENTRIES = 256) (
  input wire logic clock_i, input wire logic reset_i,
  input wire ppps_pkg::ppps_pixel_in_t pixel_i, input wire logic chip_select_n_i,
  input wire logic [24*ENTRIES-1:0] lookup_table_i, input wire logic [71:0] overlay_colours_i,
  input wire ppps_pkg::ppps_colour_t colour_current_outputs_o, input wire logic timing_current_out_o);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  ppps_pkg::ppps_pixel_in_t a, d;
  logic b, c;
  logic [1:0] rs;
  wire ok = rs == 2'h0;
  wire u = ok && c && d.blank_n;
  wire [23:0] o = colour_current_outputs_o;
  always_ff @(posedge clock_i) {rs, a, d, b, c} <= {rs[0], reset_i, pixel_i, a, chip_select_n_i, b};
  property p_s; ok |-> timing_current_out_o == d.sync_n; endproperty
  property p_x; ok && !c |-> timing_current_out_o == d.sync_n; endproperty
  property p_c; ok && !c |-> o == 24'h0; endproperty
  property p_b; ok && c && !d.blank_n |-> o == 24'h0; endproperty
  property p_v; u && d.overlay_select != 2'h0 |-> o == overlay_colours_i[24*(d.overlay_select-1)+:24]; endproperty
  property p_m; u && d.overlay_select == 2'h0 |-> o == lookup_table_i[24*d.pixel_index+:24]; endproperty
  property p_1; u && d.overlay_select == 2'h1 |-> o == overlay_colours_i[23:0]; endproperty
  property p_3; u && d.overlay_select == 2'h3 |-> o == overlay_colours_i[71:48]; endproperty
  a_s: assert property (p_s) else $error("sync");
  a_x: assert property (p_x) else $error("sync cs");
  a_c: assert property (p_c) else $error("black");
  a_b: assert property (p_b) else $error("blank");
  a_v: assert property (p_v) else $error("overlay");
  a_m: assert property (p_m) else $error("lookup");
  a_1: assert property (p_1) else $error("ovl one");
  a_3: assert property (p_3) else $error("ovl three");
  cover property (ok && !c);
  cover property (u && d.overlay_select == 2'h2);
  cover property (ok && !d.sync_n);
endmodule : ppps_props
bind ppps_pixel_port ppps_props #(.ENTRIES(ENTRIES)) u_props (.*);
`default_nettype wire

// *** bench/ppps_ctrl.sv ***
// Display controller model feeding the pixel port.
`default_nettype none
module ppps_ctrl (
  input  wire logic [15:0]             r_i,
  output ppps_pkg::ppps_pixel_in_t     pixel_o,
  output logic                         chip_select_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sync is only pulled low inside blanking.
  assign pixel_o = {r_i[7:0], r_i[9:8], r_i[10], r_i[10] | r_i[11]};
  assign chip_select_n_o = |r_i[13:12];
endmodule : ppps_ctrl
`default_nettype wire

// *** bench/ppps_pixel_port_tb_top.sv ***
// Self-checking bench for the pixel port.
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t output", $time); end end
module ppps_pixel_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, reset_i = 1'b1, cs_n, sy;
  logic [15:0] r = 16'h0;
  logic [31:0] s = 32'h00007779;
  logic [6143:0] lt;
  logic [71:0] ov = 72'h3c5a7e_a1b2c3_d4e5f6;
  ppps_pkg::ppps_pixel_in_t px;
  ppps_pkg::ppps_colour_t out;
  logic [24:0] q[$];
  int num_errors = 0, compares = 0;
  always #4 clock_i = ~clock_i;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  ppps_ctrl ctrl (.r_i(r), .pixel_o(px), .chip_select_n_o(cs_n));
  ppps_pixel_port uut (.clock_i(clock_i), .reset_i(reset_i), .pixel_i(px), .chip_select_n_i(cs_n),
    .lookup_table_i(lt), .overlay_colours_i(ov), .colour_current_outputs_o(out), .timing_current_out_o(sy));
  always @(posedge clock_i)
    if (reset_i) q = {};
    else q.push_back({!cs_n || !px.blank_n ? 24'h0 : px.overlay_select != 2'h0 ?
      ov[24*(px.overlay_select-1)+:24] : lt[24*px.pixel_index+:24], px.sync_n});
  always @(negedge clock_i)
    if (q.size() == 2) `CHK({out, sy}, q.pop_front())
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    for (int i = 0; i < 256; i++) lt[24*i+:24] = 24'(i * 40503);
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (600)
    begin
      @(posedge clock_i);
      s = xs(s);
      r <= s[15:0];
    end
    repeat (3) @(posedge clock_i);
    $display("random pixel stream test done");
    tally_and_finish();
  end
endmodule : ppps_pixel_port_tb_top
`default_nettype wire
